// ==== lcdk_defs.vh ====
// Constants for the segment display driver with key matrix scan
`ifndef LCDK_DEFS_VH
`define LCDK_DEFS_VH

// Clock rates in Hz
`define LCDK_CLK_HZ        125000000
`define LCDK_BASE_HZ       32768

// Same two rates at the width of the base clock accumulator
`define LCDK_BASE_STEP     28'h000_8000
`define LCDK_CLK_WRAP      28'h773_5940

// Frame frequencies in Hz, per duty and per speed setting
`define LCDK_F2_SLOW       16
`define LCDK_F2_TYP        32
`define LCDK_F2_FAST       64
`define LCDK_F3_SLOW       21
`define LCDK_F3_TYP        42
`define LCDK_F3_FAST       85
`define LCDK_F4_SLOW       16
`define LCDK_F4_TYP        32
`define LCDK_F4_FAST       64
`define LCDK_F5_SLOW       25
`define LCDK_F5_TYP        51
`define LCDK_F5_FAST       102

// Scan slots per common per frame
`define LCDK_SCAN_FACTOR   2

// Speed settings of the frame frequency option
`define LCDK_SPEED_SLOW    2'h0
`define LCDK_SPEED_TYP     2'h1
`define LCDK_SPEED_FAST    2'h2
`define LCDK_SPEED_UNUSED  2'h3

// Bias settings
`define LCDK_BIAS_HALF     1'b0
`define LCDK_BIAS_THIRD    1'b1

// Transfer kinds
`define LCDK_XFER_DECODE   2'h0
`define LCDK_XFER_BLANK    2'h1
`define LCDK_XFER_RAW      2'h2

// Digit decoder patterns, bit 0 is line A, bit 7 is line H
`define LCDK_DIG0          8'hbf
`define LCDK_DIG1          8'h86
`define LCDK_DIG2          8'hdb
`define LCDK_DIG3          8'hcf
`define LCDK_DIG4          8'he6
`define LCDK_DIG5          8'hed
`define LCDK_DIG6          8'hfd
`define LCDK_DIG7          8'h87
`define LCDK_DIG8          8'hff
`define LCDK_DIG9          8'hef
`define LCDK_DIG_NONE      8'h00
`define LCDK_LINE_F        5

// Flag clear operand of the key halt release request
`define LCDK_CLR_KEY_REQ   8'h20

// Panel geometry
`define LCDK_NUM_SEG       27
`define LCDK_NUM_COM       5
`define LCDK_NUM_KEY_COL   12

`endif

// ==== lcdk_driver.v ====
// Segment display driver with strobed latches, duty multiplexer and key matrix scan
//
// How it works
// [R1] Software sets unused port C pins to output before relying on key scan.
// [R2] A key return input going high during a scan raises the request flag.
// [R3] Request with enable already set raises start condition and releases halt.
// [R4] Key return levels are captured into the port C latch after each scan.
// [R5] Flag clear with operand 20h clears the key halt release request flag.
// [R6] Scan rate is frame rate times commons times two, one per slot.
// [R7] Reset forces all latches lit or unlit, held until a transfer changes them.
// [R8] Duty 2..5 with half bias, duty 3..5 with third bias, fixed at build.
// [R9] Frame timing is divided down from a 32768 Hz base clock.
// [R10] Half duty frames at 16, 32 or 64 Hz; unused option stops alternation.
// [R11] Third duty frames at 21, 42 or 85 Hz.
// [R12] Quarter duty frames at 16, 32 or 64 Hz.
// [R13] Fifth duty frames at 25, 51 or 102 Hz.
// [R14] Any segment pin may be a static push-pull or high-side open-drain output.
// [R15] Static outputs keep their value in stop mode and with display off.
// [R16] Decoder maps digits 0 to 4 to fixed patterns, A to F to zero.
// [R17] Decoder maps digits 5 to 9 to fixed patterns.
// [R18] Line F for digit 7 is a build option.
// [R19] Latch select field picks one strobe that loads the selected latches.
// [R20] Multiplexer steps stored latches onto segment pins per configured duty.
// [R21] Each segment pin holds five latches, one per common slot.
// [R22] Thirty-two strobes, numbered 0h to 1Fh.
// [R23] Blanking transfer forces all lines low when the source is zero.
// [R24] Display off and on blank or restore outputs without touching latches.
// [R25] A common counter steps through the commons and flips polarity each half frame.
`include "lcdk_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module lcdk_driver #(
    parameter integer DUTY        = 5,                  // Number of commons, 2 to 5
    parameter         BIAS        = `LCDK_BIAS_THIRD,   // Bias option
    parameter [1:0]   SPEED       = `LCDK_SPEED_TYP,    // Frame frequency option
    parameter         F_ON_SEVEN  = 1'b1,               // Line F for digit 7
    parameter         RESET_LIT   = 1'b0,               // Latches loaded lit by reset
    parameter [26:0]  STATIC_MASK = 27'h000_0000,       // Pins used as static outputs
    parameter [26:0]  OPEN_DRAIN  = 27'h000_0000        // Static pins of open-drain type
) (
    input  wire        clk,                        // System clock, 125 MHz
    input  wire        rst,                        // Asynchronous reset, active high
    input  wire        xfer_valid,                 // Display transfer instruction pulse
    input  wire [1:0]  xfer_kind,                  // Decoded, blanking or raw transfer
    input  wire [7:0]  xfer_data,                  // Raw lines, or digit in low nibble
    input  wire [4:0]  latch_select_field,         // Strobe number of the transfer
    input  wire        display_off_instruction,    // Blank the panel pulse
    input  wire        display_on_instruction,     // Restore the panel pulse
    input  wire        stop_mode,                  // Processor in stop state
    input  wire        flag_clear_instruction,     // Flag clear pulse
    input  wire [7:0]  flag_clear_operand,         // Operand of the flag clear
    input  wire        key_halt_release_enable,    // Halt release enable flag
    input  wire        start_flag_clear,           // Clears the start condition flag
    input  wire        halted,                     // Processor is in halt mode
    input  wire [11:0] scan_column_outputs,        // Columns driven high in scan slots
    input  wire [3:0]  key_return_inputs,          // Key return pins, pulled low
    output reg  [4:0]  com_select,                 // Selected common, one-hot, all zero while the panel is dark
    output reg         frame_phase,                // Drive polarity of this half frame
    output reg  [26:0] seg_out,                    // Segment pin output value
    output reg  [26:0] seg_oe_n,                   // Segment pin output enable, low drives
    output reg         scan_active,                // Key scan interval in progress
    output reg  [3:0]  port_c,                     // Latched key return levels
    output reg         key_halt_release_request,   // Key halt release request flag
    output reg         key_start_condition_flag,   // Key start condition flag
    output reg         halt_release                // Halt release pulse
);

    // Frame rate of the configured duty and speed
    localparam integer FRAME_HZ =
        (DUTY == 2) ? ((SPEED == `LCDK_SPEED_SLOW) ? `LCDK_F2_SLOW :
                       (SPEED == `LCDK_SPEED_FAST) ? `LCDK_F2_FAST : `LCDK_F2_TYP) :
        (DUTY == 3) ? ((SPEED == `LCDK_SPEED_SLOW) ? `LCDK_F3_SLOW :
                       (SPEED == `LCDK_SPEED_FAST) ? `LCDK_F3_FAST : `LCDK_F3_TYP) :
        (DUTY == 4) ? ((SPEED == `LCDK_SPEED_SLOW) ? `LCDK_F4_SLOW :
                       (SPEED == `LCDK_SPEED_FAST) ? `LCDK_F4_FAST : `LCDK_F4_TYP) :
                      ((SPEED == `LCDK_SPEED_SLOW) ? `LCDK_F5_SLOW :
                       (SPEED == `LCDK_SPEED_FAST) ? `LCDK_F5_FAST : `LCDK_F5_TYP);

    // Base ticks per common slot; one scan interval per slot
    localparam integer SLOT_TICKS =
        `LCDK_BASE_HZ / (FRAME_HZ * DUTY * `LCDK_SCAN_FACTOR);    // [R6]
    localparam [9:0]  SLOT_LAST  = SLOT_TICKS[9:0] - 10'h001;
    localparam [2:0]  COM_LAST   = DUTY[2:0] - 3'h1;
    localparam [4:0]  LATCH_INIT = RESET_LIT ? 5'h1f : 5'h00;
    localparam [26:0] ALL_ZERO   = 27'h000_0000;

    // Only the documented duty and bias pairs alternate; other pairs build but stay idle
    localparam LEGAL_OPTION = (DUTY >= 2) && (DUTY <= 5) &&
                              ((BIAS == `LCDK_BIAS_HALF) || (DUTY >= 3));    // [R8]

    // Digit decoder; unmapped codes give a dark digit
    function [7:0] decode_digit;
        input [3:0] value;
        begin
            case (value)
                4'h0:    decode_digit = `LCDK_DIG0;    // [R16]
                4'h1:    decode_digit = `LCDK_DIG1;
                4'h2:    decode_digit = `LCDK_DIG2;
                4'h3:    decode_digit = `LCDK_DIG3;
                4'h4:    decode_digit = `LCDK_DIG4;
                4'h5:    decode_digit = `LCDK_DIG5;    // [R17]
                4'h6:    decode_digit = `LCDK_DIG6;
                4'h7:    decode_digit = `LCDK_DIG7 | ({7'h00, F_ON_SEVEN} << `LCDK_LINE_F); // [R18]
                4'h8:    decode_digit = `LCDK_DIG8;
                4'h9:    decode_digit = `LCDK_DIG9;
                default: decode_digit = `LCDK_DIG_NONE;    // [R16]
            endcase
        end
    endfunction

    // Base clock enable by fractional accumulation, exact on average
    reg  [26:0] base_acc;
    wire [27:0] base_sum  = {1'b0, base_acc} + `LCDK_BASE_STEP;
    wire        base_wrap = (base_sum >= `LCDK_CLK_WRAP);
    wire [27:0] base_rem  = base_sum - `LCDK_CLK_WRAP;
    reg         base_tick;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            base_acc  <= 27'h000_0000;
            base_tick <= 1'b0;
        end else if (base_wrap) begin
            base_acc  <= base_rem[26:0];    // [R9]
            base_tick <= 1'b1;
        end else begin
            base_acc  <= base_sum[26:0];
            base_tick <= 1'b0;
        end
    end

    // Slot timing: tick counter, common counter, polarity
    reg  [9:0] slot_cnt;
    reg  [2:0] com_idx;
    reg        phase;
    wire       alternate = LEGAL_OPTION && (SPEED != `LCDK_SPEED_UNUSED);    // [R10]
    wire       slot_end  = base_tick && alternate && (slot_cnt == SLOT_LAST);
    wire       in_scan   = alternate && (slot_cnt == SLOT_LAST);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slot_cnt <= 10'h000;
            com_idx  <= 3'h0;
            phase    <= 1'b0;
        end else if (slot_end) begin
            slot_cnt <= 10'h000;
            if (com_idx == COM_LAST) begin
                com_idx <= 3'h0;    // [R25]
                phase   <= ~phase;  // [R25]
            end else begin
                com_idx <= com_idx + 3'h1;    // [R20]
            end
        end else if (base_tick && alternate) begin
            slot_cnt <= slot_cnt + 10'h001;    // [R11] [R12] [R13]
        end
    end

    // Data lines of the current transfer
    reg [7:0] next_lines;

    always @* begin
        case (xfer_kind)
            `LCDK_XFER_RAW:   next_lines = xfer_data;
            `LCDK_XFER_BLANK: next_lines = (xfer_data[3:0] == 4'h0) ? 8'h00 :
                                           decode_digit(xfer_data[3:0]);    // [R23]
            default:          next_lines = decode_digit(xfer_data[3:0]);
        endcase
    end

    // One strobe of thirty-two, from the latch select field
    wire [31:0] latch_strobe = xfer_valid ? (32'h0000_0001 << latch_select_field)
                                          : 32'h0000_0000;    // [R19] [R22]

    // Lighting latches: pin p, slot c loads line c on strobe p
    reg [4:0] seg_latch [0:26];    // [R21]
    integer   p;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (p = 0; p < `LCDK_NUM_SEG; p = p + 1) begin
                seg_latch[p] <= LATCH_INIT;    // [R7]
            end
        end else begin
            for (p = 0; p < `LCDK_NUM_SEG; p = p + 1) begin
                if (latch_strobe[p]) begin
                    seg_latch[p] <= next_lines[4:0];    // [R19]
                end
            end
        end
    end

    // Display on state; off keeps the latches so updates show on return
    reg display_on;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            display_on <= 1'b1;
        end else if (display_off_instruction) begin
            display_on <= 1'b0;    // [R24]
        end else if (display_on_instruction) begin
            display_on <= 1'b1;    // [R24]
        end
    end

    // Key return sampling; a low before the scan and a high in it is a press
    reg  [3:0] key_prev;
    wire       key_rise  = in_scan && base_tick && |(key_return_inputs & ~key_prev);
    wire       clear_req = flag_clear_instruction &&
                           (flag_clear_operand == `LCDK_CLR_KEY_REQ);
    wire       start_set = key_rise && key_halt_release_enable;

    // Pins not used for keys are assumed driven by software, so no floating input
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            key_prev <= 4'h0;
            port_c   <= 4'h0;
        end else if (base_tick) begin
            key_prev <= key_return_inputs;    // [R1]
            if (slot_end) begin
                port_c <= key_return_inputs;    // [R4]
            end
        end
    end

    // Flags; a set in the cycle of its clear wins
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            key_halt_release_request <= 1'b0;
            key_start_condition_flag <= 1'b0;
            halt_release             <= 1'b0;
        end else begin
            if (key_rise) begin
                key_halt_release_request <= 1'b1;    // [R2]
            end else if (clear_req) begin
                key_halt_release_request <= 1'b0;    // [R5]
            end
            if (start_set) begin
                key_start_condition_flag <= 1'b1;    // [R3]
            end else if (start_flag_clear) begin
                key_start_condition_flag <= 1'b0;
            end
            halt_release <= start_set && halted;    // [R3]
        end
    end

    // Pin drive, built combinationally and registered once
    reg [26:0] next_seg_out;
    reg [26:0] next_seg_oe_n;
    reg [4:0]  next_com;
    reg        panel_live;
    reg        static_val;
    integer    s;

    always @* begin
        next_seg_out  = ALL_ZERO;
        next_seg_oe_n = ALL_ZERO;
        next_com      = 5'h00;
        panel_live    = display_on && !stop_mode && alternate;
        static_val    = 1'b0;
        if (panel_live) begin
            next_com = 5'h01 << com_idx;    // [R20]
        end
        for (s = 0; s < `LCDK_NUM_SEG; s = s + 1) begin
            if (STATIC_MASK[s]) begin
                // Static pins use slot 0 and ignore stop and display off
                static_val       = seg_latch[s][0];    // [R15]
                next_seg_out[s]  = static_val;    // [R14]
                next_seg_oe_n[s] = OPEN_DRAIN[s] ? ~static_val : 1'b0;    // [R14]
            end else if (s < `LCDK_NUM_KEY_COL && in_scan && !stop_mode) begin
                // Scan slot borrows the column pins; idle columns float
                next_seg_out[s]  = scan_column_outputs[s];    // [R6]
                next_seg_oe_n[s] = ~scan_column_outputs[s];
            end else if (panel_live) begin
                next_seg_out[s]  = seg_latch[s][com_idx] ^ phase;    // [R20]
            end
        end
    end

    // Registered outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            com_select  <= 5'h00;
            frame_phase <= 1'b0;
            seg_out     <= ALL_ZERO;
            seg_oe_n    <= ALL_ZERO;
            scan_active <= 1'b0;
        end else begin
            com_select  <= next_com;
            frame_phase <= phase;
            seg_out     <= next_seg_out;
            seg_oe_n    <= next_seg_oe_n;
            scan_active <= in_scan && !stop_mode;
        end
    end

endmodule // lcdk_driver

`default_nettype wire

// ==== lcdk_asserts.sv ====
// Checker of the segment display driver port behaviour
`timescale 1ns/10ps
`default_nettype none
module lcdk_asserts #(
    parameter [26:0] STATIC_MASK = 27'h000_0000, // Static pins
    parameter [26:0] OPEN_DRAIN  = 27'h000_0000  // Open-drain static pins
) (
    input wire logic        clk,                      // Clock
    input wire logic        rst,                      // Reset
    input wire logic        xfer_valid,               // Transfer pulse
    input wire logic        display_off_instruction,  // Blank pulse
    input wire logic        display_on_instruction,   // Restore pulse
    input wire logic        flag_clear_instruction,   // Flag clear pulse
    input wire logic [7:0]  flag_clear_operand,       // Flag clear operand
    input wire logic        key_halt_release_enable,  // Enable flag
    input wire logic        scan_active,              // Scan interval
    input wire logic [4:0]  com_select,               // Common select
    input wire logic [26:0] seg_out,                  // Segment values
    input wire logic [26:0] seg_oe_n,                 // Segment enables
    input wire logic        key_halt_release_request, // Request flag
    input wire logic        key_start_condition_flag, // Start flag
    input wire logic        halt_release              // Release pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Blank pulse followed by two cycles with no restore
    sequence s_off_quiet;
        display_off_instruction ##1 !display_on_instruction ##1 !display_on_instruction;
    endsequence
    // Start flag present while the release pulse ends after one cycle
    sequence s_release_pulse;
        key_start_condition_flag ##1 !halt_release;
    endsequence
    property p_off_blank;
        s_off_quiet |-> com_select == 5'h00 &&
            (seg_out & ~STATIC_MASK & (scan_active ? 27'h7ff_f000 : 27'h7ff_ffff))
                == 27'h000_0000;
    endproperty
    property p_static_hold;
        !$past(xfer_valid) && !$past(xfer_valid, 2) && !$past(xfer_valid, 3) && !$past(rst)
            && !$past(rst, 2) |-> $stable(seg_out & STATIC_MASK);
    endproperty
    property p_push_pull;
        (seg_oe_n & STATIC_MASK & ~OPEN_DRAIN) == 27'h000_0000;
    endproperty
    property p_open_drain;
        !$past(rst) && !$past(rst, 2) |->
            (seg_oe_n & STATIC_MASK & OPEN_DRAIN) == (~seg_out & STATIC_MASK & OPEN_DRAIN);
    endproperty
    property p_onehot;
        $onehot0(com_select);
    endproperty
    property p_clear;
        flag_clear_instruction && flag_clear_operand == 8'h20 && !scan_active
            |=> !key_halt_release_request;
    endproperty
    property p_other_operand;
        flag_clear_instruction && flag_clear_operand != 8'h20 && key_halt_release_request
            |=> key_halt_release_request;
    endproperty
    property p_start;
        $rose(key_start_condition_flag) |->
            key_halt_release_request && $past(key_halt_release_enable);
    endproperty
    property p_release;
        halt_release |-> s_release_pulse;
    endproperty
    a_off_blank: assert property (p_off_blank)
        else $error("panel not blanked after off");
    a_static_hold: assert property (p_static_hold)
        else $error("static pin changed without transfer");
    a_push_pull: assert property (p_push_pull)
        else $error("push-pull static pin not driven");
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain enable wrong");
    a_onehot: assert property (p_onehot)
        else $error("more than one common selected");
    a_clear: assert property (p_clear)
        else $error("request not cleared");
    a_other_operand: assert property (p_other_operand)
        else $error("request cleared by other operand");
    a_start: assert property (p_start)
        else $error("start flag without request and enable");
    a_release: assert property (p_release)
        else $error("release pulse wrong");
endmodule // lcdk_asserts
`default_nettype wire

// ==== lcdk_keypad.sv ====
// Key matrix model joining driven scan columns to return rows
`timescale 1ns/10ps
`default_nettype none
module lcdk_keypad (
    input  wire logic        scan_active,      // Scan interval
    input  wire logic [11:0] columns,          // Columns driven high
    input  wire logic [47:0] pressed,          // Switch at row*12+col closed
    output logic      [3:0]  key_return_inputs // Return rows
);
    // Rows fall to the pull-low level outside scan intervals
    // Unused port C pins are taken as already switched to outputs by software
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            key_return_inputs[r] = scan_active && |(columns & pressed[r*12 +: 12]);
        end
    end
endmodule // lcdk_keypad
`default_nettype wire

// ==== lcdk_tb.sv ====
// Testbench of the segment display driver with key matrix scan
`include "lcdk_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int TICK = `LCDK_CLK_HZ / `LCDK_BASE_HZ;
    localparam int SLOT = `LCDK_BASE_HZ / (`LCDK_F5_FAST * 5 * `LCDK_SCAN_FACTOR);
    localparam logic [15:0] LINE_A = 16'h03ed; // Line A per digit
    logic        clk, rst, xfer_valid, display_off_instruction, display_on_instruction;
    logic        stop_mode, flag_clear_instruction, key_halt_release_enable;
    logic        start_flag_clear, halted;
    logic [1:0]  xfer_kind;
    logic [7:0]  xfer_data, flag_clear_operand;
    logic [4:0]  latch_select_field;
    logic [11:0] scan_column_outputs;
    logic [47:0] pressed;
    wire  [3:0]  key_return_inputs, port_c;
    wire  [4:0]  com_select;
    wire  [26:0] seg_out, seg_oe_n;
    wire         scan_active, key_halt_release_request, key_start_condition_flag, halt_release;
    wire         frame_phase;
    int          mismatches, checked, cycles, rel, n;
    lcdk_driver #(.DUTY(5), .SPEED(`LCDK_SPEED_FAST), .RESET_LIT(1'b0),
        .STATIC_MASK(27'h000_0003), .OPEN_DRAIN(27'h000_0002)) dut_u (.clk, .rst, .xfer_valid,
        .xfer_kind, .xfer_data, .latch_select_field, .display_off_instruction,
        .display_on_instruction, .stop_mode, .flag_clear_instruction, .flag_clear_operand,
        .key_halt_release_enable, .start_flag_clear, .halted, .scan_column_outputs,
        .key_return_inputs, .com_select, .frame_phase, .seg_out, .seg_oe_n, .scan_active,
        .port_c, .key_halt_release_request, .key_start_condition_flag, .halt_release);
    lcdk_keypad kp_u (.scan_active, .columns(seg_out[11:0] & ~seg_oe_n[11:0]), .pressed,
        .key_return_inputs);
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard, sized for one slot of the fastest setting
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 150000) begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end
    task automatic chk(input string name, input logic [26:0] exp, input logic [26:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input logic [1:0] kind, input logic [7:0] data, input logic [4:0] f);
        xfer_valid <= 1'b1;
        xfer_kind <= kind;
        xfer_data <= data;
        latch_select_field <= f;
        @(posedge clk);
        xfer_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic clear_flag(input logic [7:0] op);
        flag_clear_instruction <= 1'b1;
        flag_clear_operand <= op;
        @(posedge clk);
        flag_clear_instruction <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Decoder seen through static pin 0, which follows the slot 0 latch
    task automatic t_decode;
        for (int d = 0; d < 16; d++) begin
            xfer(`LCDK_XFER_DECODE, 8'(d), 5'h00);
            chk("line_a", 27'(LINE_A[d]), 27'(seg_out[0]));
        end
        xfer(`LCDK_XFER_BLANK, 8'h00, 5'h00);
        chk("blank_zero", 27'h000_0000, 27'(seg_out[0]));
        xfer(`LCDK_XFER_BLANK, 8'h02, 5'h00);
        chk("blank_two", 27'h000_0001, 27'(seg_out[0]));
    endtask
    // Strobes pick pins; unmapped strobes load nothing
    task automatic t_strobe;
        xfer(`LCDK_XFER_RAW, 8'h01, 5'h01);
        chk("od_on", 27'h000_0003, seg_out[1:0] | (27'(seg_oe_n[1]) << 2));
        xfer(`LCDK_XFER_RAW, 8'h00, 5'h1b);
        xfer(`LCDK_XFER_RAW, 8'h00, 5'h1f);
        chk("unmapped", 27'h000_0003, 27'(seg_out[1:0]));
        xfer(`LCDK_XFER_RAW, 8'h00, 5'h01);
        chk("od_off", 27'h000_0005, seg_out[1:0] | (27'(seg_oe_n[1]) << 2));
    endtask
    // Blanking and stop keep static pins and dark the panel
    task automatic t_off_stop;
        display_off_instruction <= 1'b1;
        @(posedge clk);
        display_off_instruction <= 1'b0;
        repeat (3) @(posedge clk);
        // Pin 2 is loaded while blanked, so it must stay dark until restored
        xfer(`LCDK_XFER_RAW, 8'h01, 5'h02);
        chk("off", 27'h000_0001, {com_select, seg_out[21:0]});
        display_on_instruction <= 1'b1;
        stop_mode <= 1'b1;
        @(posedge clk);
        display_on_instruction <= 1'b0;
        repeat (3) @(posedge clk);
        chk("stop", 27'h000_0001, {com_select, seg_out[21:0]});
        stop_mode <= 1'b0;
        repeat (2) @(posedge clk);
        chk("restore", 27'h040_0005, {com_select, seg_out[21:0]});
    endtask
    // One key press across a full slot of the scan
    task automatic t_key;
        pressed <= 48'h1 << 29;
        key_halt_release_enable <= 1'b1;
        halted <= 1'b1;
        // Flags and pulses are read at the falling edge, where they are settled
        for (n = 0; n < 140000 && scan_active !== 1'b1; n++) @(negedge clk);
        n = cycles - rel;
        chk("slot", 27'h1, 27'(n > (SLOT - 2) * TICK && n < (SLOT + 1) * TICK));
        for (n = 0; n < 2 * TICK && key_halt_release_request !== 1'b1; n++) @(negedge clk);
        chk("flags", 27'h7, {halt_release, key_start_condition_flag,
            key_halt_release_request});
        @(negedge clk);
        chk("pulse", 27'h0, 27'(halt_release));
        for (n = 0; n < 2 * TICK && scan_active !== 1'b0; n++) @(negedge clk);
        repeat (2) @(posedge clk);
        chk("port_c", 27'h4, 27'(port_c));
        chk("com", 27'h2, {frame_phase, com_select});
        clear_flag(8'h10);
        chk("kept", 27'h1, 27'(key_halt_release_request));
        clear_flag(8'h20);
        chk("cleared", 27'h0, 27'(key_halt_release_request));
        start_flag_clear <= 1'b1;
        @(posedge clk);
        start_flag_clear <= 1'b0;
        repeat (2) @(posedge clk);
        chk("start_clr", 27'h0, 27'(key_start_condition_flag));
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst, xfer_valid, display_off_instruction, display_on_instruction} = 4'h8;
        {stop_mode, flag_clear_instruction, key_halt_release_enable} = 3'h0;
        {start_flag_clear, halted, xfer_kind, xfer_data, flag_clear_operand} = 20'h0_0000;
        latch_select_field = 5'h00;
        scan_column_outputs = 12'hfff;
        pressed = 48'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rel = cycles;
        repeat (3) @(posedge clk);
        chk("reset", 27'h000_0004, seg_out[1:0] | (27'(seg_oe_n[1]) << 2));
        t_decode();
        t_strobe();
        t_off_stop();
        t_key();
        report_and_stop();
    end
endmodule // testbench
bind lcdk_driver lcdk_asserts #(.STATIC_MASK(STATIC_MASK), .OPEN_DRAIN(OPEN_DRAIN)) chk_u (
    .clk, .rst, .xfer_valid, .display_off_instruction, .display_on_instruction,
    .flag_clear_instruction, .flag_clear_operand, .key_halt_release_enable, .scan_active,
    .com_select, .seg_out, .seg_oe_n, .key_halt_release_request, .key_start_condition_flag,
    .halt_release);
`default_nettype wire
